//--- logic/gcod_pkg.sv
package gcod_pkg;
  // ************************************************
  // Register map
  // ************************************************
  localparam logic [7:0] GCOD_SETUP_ADDR = 8'h8F;
  localparam logic [7:0] GCOD_SETUP_RESET = 8'h00;
  localparam int GCOD_CLR_BIT = 7;
  localparam int GCOD_INV_BIT = 6;
  localparam int GCOD_SYM_BIT = 5;
  localparam int GCOD_DIV_MSB = 4;
  localparam int GCOD_DIV_W = 5;
  localparam int GCOD_PINS = 2;
  localparam logic [4:0] GCOD_DIV_RESET = 5'h00;
  localparam logic [4:0] GCOD_CNT_RESET = 5'h00;
  localparam logic [4:0] GCOD_DIV_MIN = 5'h02;
  localparam logic [4:0] GCOD_CNT_LAST = 5'h01;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcod_sfr_req_t;

  typedef struct packed {
    logic inv;
    logic sym;
    logic [4:0] div;
  } gcod_cfg_t;

  typedef enum logic [1:0] {GCOD_IDLE, GCOD_RUN} gcod_state_t;
endpackage

//--- logic/gcod_sfr.sv
`timescale 1ns/1ps
module gcod_sfr (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire gcod_pkg::gcod_sfr_req_t req,
  input wire logic idle,
  output logic [7:0] rdata,
  output gcod_pkg::gcod_cfg_t cfg,
  output logic clr_pulse
);
  import gcod_pkg::*;
  // ************************************************
  // Setup register
  // ************************************************
  logic hit;
  logic [6:0] reg_q;
  logic [6:0] reg_d;
  logic clr_q;
  logic clr_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  assign hit = req.addr == GCOD_SETUP_ADDR;

  always_comb begin
    reg_d = reg_q;
    clr_d = 1'b0;
    rdata_d = rdata_q;
    if (req.wr_en && hit) begin
      reg_d = req.wdata[6:0];
      clr_d = req.wdata[GCOD_CLR_BIT];
    end
    if (req.rd_en) begin
      rdata_d = hit ? {idle, reg_q} : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_q <= GCOD_SETUP_RESET[6:0];
      clr_q <= 1'b0;
      rdata_q <= GCOD_SETUP_RESET;
    end else begin
      reg_q <= reg_d;
      clr_q <= clr_d;
      rdata_q <= rdata_d;
    end
  end

  // Clear lines up with the registered field update
  assign clr_pulse = clr_q;
  assign rdata = rdata_q;
  assign cfg.inv = reg_q[GCOD_INV_BIT];
  assign cfg.sym = reg_q[GCOD_SYM_BIT];
  assign cfg.div = reg_q[GCOD_DIV_MSB:0];
endmodule

//--- logic/gcod_pins.sv
`timescale 1ns/1ps
module gcod_pins (
  input wire logic clk_out,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] pin_sel,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] port_out,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] port_oe,
  output logic [gcod_pkg::GCOD_PINS-1:0] pad_out,
  output logic [gcod_pkg::GCOD_PINS-1:0] pad_oe
);
  import gcod_pkg::*;
  // ************************************************
  // Pin muxing, clock wins over port
  // ************************************************
  genvar i;
  generate
    for (i = 0; i < GCOD_PINS; i++) begin : g_pin
      assign pad_out[i] = pin_sel[i] ? clk_out : port_out[i];
      assign pad_oe[i] = pin_sel[i] | port_oe[i];
    end
  endgenerate
endmodule

//--- logic/gcod_top.sv
`timescale 1ns/1ps
module gcod_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire gcod_pkg::gcod_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic clk_enable,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] pin_select,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] port_out,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] port_oe,
  output logic [gcod_pkg::GCOD_PINS-1:0] pad_out,
  output logic [gcod_pkg::GCOD_PINS-1:0] pad_oe
);
  import gcod_pkg::*;
  // ************************************************
  // Register slave
  // ************************************************
  gcod_cfg_t cfg;
  logic divider_clear;
  logic idle;

  gcod_sfr u_sfr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req(sfr_req),
    .idle(idle),
    .rdata(sfr_rdata),
    .cfg(cfg),
    .clr_pulse(divider_clear)
  );

  // ************************************************
  // Divider
  // ************************************************
  gcod_state_t state_q;
  gcod_state_t state_d;
  logic [4:0] div_q;
  logic [4:0] div_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic pos_q;
  logic pos_d;
  logic neg_q;
  logic neg_d;
  logic pass_q;
  logic pass_d;
  logic pass_gate_q;
  logic pass_gate_d;
  logic [4:0] half;
  logic [4:0] new_half;
  logic raw_clk;
  logic gen_clk;
  logic start_ok;

  // Enable is a signal from the port setup register, same clock
  assign start_ok = clk_enable;
  // Low phase length: floor(div/2), the high phase gets the extra cycle
  assign half = {1'b0, div_q[4:1]};
  assign new_half = {1'b0, cfg.div[4:1]};

  always_comb begin
    state_d = state_q;
    div_d = div_q;
    cnt_d = cnt_q;
    pos_d = pos_q;
    pass_d = 1'b0;
    if (divider_clear) begin
      state_d = GCOD_IDLE;
      cnt_d = GCOD_CNT_RESET;
      pos_d = 1'b0;
      div_d = cfg.div;
    end else begin
      case (state_q)
        GCOD_IDLE: begin
          div_d = cfg.div;
          pos_d = 1'b0;
          if (start_ok) begin
            if (cfg.div >= GCOD_DIV_MIN) begin
              state_d = GCOD_RUN;
              cnt_d = new_half;
            end else begin
              pass_d = 1'b1;
            end
          end
        end
        GCOD_RUN: begin
          if (cnt_q > GCOD_CNT_LAST) begin
            cnt_d = cnt_q - GCOD_CNT_LAST;
          end else if (!pos_q) begin
            pos_d = 1'b1;
            cnt_d = div_q - half;
          end else begin
            // End of period: pick up the new factor or stop
            pos_d = 1'b0;
            div_d = cfg.div;
            if (start_ok && cfg.div >= GCOD_DIV_MIN) begin
              cnt_d = new_half;
            end else begin
              state_d = GCOD_IDLE;
              cnt_d = GCOD_CNT_RESET;
            end
          end
        end
        default: begin
          state_d = GCOD_IDLE;
          cnt_d = GCOD_CNT_RESET;
          pos_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= GCOD_IDLE;
      div_q <= GCOD_DIV_RESET;
      cnt_q <= GCOD_CNT_RESET;
      pos_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      pos_q <= pos_d;
      pass_q <= pass_d;
    end
  end

  // Falling-edge copy trims half a cycle off the high phase
  always_comb begin
    neg_d = pos_q & ~divider_clear;
    pass_gate_d = pass_q & ~divider_clear;
  end

  // Gate opens and closes only while the oscillator is low
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_q <= 1'b0;
      pass_gate_q <= 1'b0;
    end else begin
      neg_q <= neg_d;
      pass_gate_q <= pass_gate_d;
    end
  end

  assign idle = state_q == GCOD_IDLE;

  // ************************************************
  // Output chain
  // ************************************************
  // Balanced mode ANDs two flops for odd factors; jitter traded for 1:1 duty
  always_comb begin
    if (pass_gate_q) begin
      raw_clk = core_clk;
    end else if (cfg.sym && div_q[0]) begin
      raw_clk = pos_q & neg_q;
    end else begin
      raw_clk = pos_q;
    end
  end

  // Inversion is unsynchronised and may glitch
  assign gen_clk = raw_clk ^ cfg.inv;

  gcod_pins u_pins (
    .clk_out(gen_clk),
    .pin_sel(pin_select),
    .port_out(port_out),
    .port_oe(port_oe),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );
endmodule

//--- dv/gcod_top_assertions.sv
`timescale 1ns/1ps
module gcod_top_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire gcod_pkg::gcod_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic clk_enable,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] pin_select,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] port_out,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] port_oe,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] pad_out,
  input wire logic [gcod_pkg::GCOD_PINS-1:0] pad_oe
);
  import gcod_pkg::*;
  // ****
  // Port checks
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic hit;
  assign hit = sfr_req.addr == GCOD_SETUP_ADDR;
  sequence s_clr_stop;
    sfr_req.wr_en && hit && sfr_req.wdata[7] && !clk_enable ##1 !clk_enable;
  endsequence
  sequence s_wr_rd;
    sfr_req.wr_en && hit ##1 !sfr_req.wr_en ##1 sfr_req.rd_en && hit;
  endsequence
  chk_free_pad0: assert property (!pin_select[0] |->
    pad_out[0] == port_out[0] && pad_oe[0] == port_oe[0]) else $error("pad0");
  chk_free_pad1: assert property (!pin_select[1] |->
    pad_out[1] == port_out[1] && pad_oe[1] == port_oe[1]) else $error("pad1");
  chk_sel_drive: assert property (|pin_select |->
    (pin_select & ~pad_oe) == 2'h0) else $error("pad not driven");
  chk_pads_same: assert property (&pin_select |->
    pad_out[0] == pad_out[1]) else $error("pads differ");
  chk_clr_rest: assert property (s_clr_stop |=>
    !pin_select[0] || pad_out[0] == $past(sfr_req.wdata[6], 2))
    else $error("clear rest level");
  chk_idle_read: assert property (s_clr_stop ##1 sfr_req.rd_en && hit
    |=> sfr_rdata[7]) else $error("idle flag");
  chk_read_back: assert property (s_wr_rd |=>
    sfr_rdata[6:0] == $past(sfr_req.wdata[6:0], 3)) else $error("readback");
  chk_rdata_hold: assert property (!sfr_req.rd_en |=>
    $stable(sfr_rdata)) else $error("rdata moved");
endmodule
bind gcod_top gcod_top_chk chk (.core_clk, .rst_n, .sfr_req, .sfr_rdata,
  .clk_enable, .pin_select, .port_out, .port_oe, .pad_out, .pad_oe);

//--- dv/gcod_clk_sink.sv
`timescale 1ns/1ps
module gcod_clk_sink (
  input wire logic pin
);
  // ****
  // Pin meter, in ps so half cycles survive
  // ****
  realtime t_rise = 0.0;
  realtime t_fall = 0.0;
  int hi_ps = 0;
  int lo_ps = 0;
  int edges = 0;
  always @(posedge pin) begin
    lo_ps = int'(($realtime - t_fall) * 1000.0);
    t_rise = $realtime;
    edges++;
  end
  always @(negedge pin) begin
    hi_ps = int'(($realtime - t_rise) * 1000.0);
    t_fall = $realtime;
  end
endmodule

//--- dv/gcod_top_tb.sv
`timescale 1ns/1ps
module gcod_top_tb;
  import gcod_pkg::*;
  // ****
  // Bench
  // ****
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_enable = 1'b0;
  gcod_sfr_req_t sfr_req = '0;
  logic [1:0] pin_select = 2'h3;
  logic [1:0] port_out = 2'h2;
  logic [1:0] port_oe = 2'h1;
  logic [7:0] sfr_rdata;
  logic [1:0] pad_out;
  logic [1:0] pad_oe;
  int fail_count = 0;
  int samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  gcod_top dut (.core_clk, .rst_n, .sfr_req, .sfr_rdata, .clk_enable,
    .pin_select, .port_out, .port_oe, .pad_out, .pad_oe);
  gcod_clk_sink p (.pin(pad_out[0]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic r, input logic [7:0] d,
    input logic [7:0] a = GCOD_SETUP_ADDR);
    @(negedge core_clk) sfr_req = '{!r, r, a, d};
    @(negedge core_clk) sfr_req = '0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic en(input logic v);
    @(negedge core_clk) clk_enable = v;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_regs;
    acc(1, 8'h00);
    chk(sfr_rdata, 8'h80);
    acc(0, 8'h1F, 8'h8E);
    acc(1, 8'h00);
    chk(sfr_rdata, 8'h80);
    acc(1, 8'h00, 8'h8E);
    chk(sfr_rdata, 8'h00);
  endtask
  task automatic t_div;
    for (int n = 2; n < 6; n++) begin
      acc(0, 8'(n));
      en(1);
      cyc(4 * n + 4);
      chk(p.hi_ps, (n - n / 2) * 25000);
      chk(p.lo_ps, n / 2 * 25000);
      acc(1, 8'h00);
      chk(sfr_rdata[7], 0);
      @(posedge pad_out[0]);
      en(0);
      @(negedge pad_out[0]);
      chk(p.hi_ps, (n - n / 2) * 25000);
      cyc(2 * n);
      chk(pad_out[0], 0);
      acc(1, 8'h00);
      chk(sfr_rdata, 8'h80 | n);
    end
  endtask
  task automatic t_pass;
    int e;
    for (int d = 0; d < 2; d++) begin
      acc(0, 8'(d));
      en(1);
      cyc(3);
      e = p.edges;
      cyc(10);
      chk(p.edges - e, 10);
      en(0);
      cyc(3);
    end
  endtask
  task automatic t_sym;
    acc(0, 8'h25);
    en(1);
    cyc(24);
    chk(p.hi_ps + p.lo_ps, 125000);
    chk(p.hi_ps - p.lo_ps + 12500 <= 25000, 1);
    en(0);
    cyc(8);
  endtask
  task automatic t_switch_clear;
    acc(0, 8'h04);
    en(1);
    cyc(12);
    @(posedge pad_out[0]);
    acc(0, 8'h06);
    @(negedge pad_out[0]);
    chk(p.hi_ps, 50000);
    cyc(20);
    chk(p.hi_ps, 75000);
    @(posedge pad_out[0]);
    acc(0, 8'h84);
    cyc(1);
    chk(pad_out[0], 0);
    cyc(16);
    chk(p.hi_ps, 50000);
    en(0);
    acc(0, 8'h84);
    acc(1, 8'h00);
    chk(sfr_rdata, 8'h84);
  endtask
  task automatic t_inv_pins;
    acc(0, 8'h45);
    cyc(1);
    chk(pad_out[0], 1);
    en(1);
    cyc(16);
    chk(p.hi_ps, 50000);
    en(0);
    cyc(8);
    chk(pad_out[0], 1);
    acc(0, 8'h05);
    cyc(1);
    chk(pad_out[0], 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk) pin_select = 2'(i);
      cyc(1);
      chk(pad_oe, 2'(i) | port_oe);
      chk(pad_out, port_out & ~2'(i));
    end
  endtask
  initial begin
    cyc(2);
    rst_n = 1'b1;
    t_regs;
    t_div;
    t_pass;
    t_sym;
    t_switch_clear;
    t_inv_pins;
    give_verdict;
  end
  initial begin
    #200us;
    fail_count++;
    give_verdict;
  end
endmodule
